//--- rtl/svic_params.svh
`ifndef SVIC_PARAMS_SVH
`define SVIC_PARAMS_SVH

// Register indices; the byte address on the bus is four times the index.
`define IDX_SYSMODE   10'h0df
`define IDX_PEND_P1   10'h0d0
`define IDX_PEND_TS   10'h0d1
`define IDX_PEND_PX   10'h0d2
`define IDX_EN_P1     10'h0d4
`define IDX_EN_TS     10'h0d5
`define IDX_EN_PX     10'h0d6
`define IDX_EVT_STAT  10'h0d8
`define IDX_EVT_MASK  10'h0d9

`define SYSMODE_RST   8'h00
`define GIE_BIT       3
`define PAGE_MSB      2
`define EN_RST        8'h00

`define VEC_HI_ADDR   16'h0000
`define VEC_LO_ADDR   16'h0001

`define EVT_ACK       0
`define EVT_RET       1
`define EVT_BRANCH    2
`define N_EVT         3

`endif

//--- rtl/svic_pkg.sv
package svic_pkg;

  typedef enum logic [2:0]
  {
    ST_IDLE   = 3'b000,
    ST_ACK    = 3'b001,
    ST_PCL    = 3'b011,
    ST_PCH    = 3'b010,
    ST_FLG    = 3'b110,
    ST_VHI    = 3'b111,
    ST_VLO    = 3'b101,
    ST_BRANCH = 3'b100
  } svc_state_e;

endpackage

//--- rtl/pending_flag_bank.sv
`timescale 1ns/10ps
module pending_flag_bank
#(
  parameter int W       = 8,
  parameter bit SYNC_IN = 1'b0
)
(
  input  wire logic         clk_sys,   // System clock.
  input  wire logic         rst_n,     // Asynchronous reset, active low.
  input  wire logic [W-1:0] src_in,    // Event pulses or raw pin levels.
  input  wire logic         wr_stb,    // Software write to this flag register.
  input  wire logic [W-1:0] wr_data,   // Zero bits clear, one bits leave alone.
  output logic      [W-1:0] pend_flags // Sticky pending flags.
);

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic set_evt;
      if (SYNC_IN)
      begin : g_sync
        logic s1_r;
        logic s2_r;
        logic s3_r;
        always_ff @(posedge clk_sys or negedge rst_n)
        begin
          if (!rst_n)
          begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
          end
          else
          begin
            s1_r <= src_in[i];
            s2_r <= s1_r;
            s3_r <= s2_r;
          end
        end
        // Rising edge of the pin, seen only after the two-stage synchroniser.
        assign set_evt = s2_r & ~s3_r;
      end
      else
      begin : g_direct
        assign set_evt = src_in[i];
      end

      // A new event in the cycle of a clearing write wins over the clear.
      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
          pend_flags[i] <= 1'b0;
        else
          pend_flags[i] <= set_evt | (pend_flags[i] & ~(wr_stb & ~wr_data[i]));
      end
    end
  endgenerate

endmodule

//--- rtl/single_vector_interrupt_control.sv
// Operation
// - All sources share one vector at 0000H/0001H.
// - Global enable is bit 3 of system mode.
// - Every source has its own enable bit.
// - Service needs global and source enable set.
// - Acknowledge only at instruction completion.
// - Acknowledge pulses and starts interrupt machine cycle.
// - Machine cycle first clears the global enable.
// - Push PC low, PC high, then flags.
// - Fetch vector high, then low, then branch.
// - Service return sets the global enable.
// - Each source sets its own pending bit.
// - No hardware priority; software polls pending bits.
// - Eight timer, serial, watch and fifteen pin sources.
// - Global enable resets to zero, disabled.
`timescale 1ns/10ps
`include "svic_params.svh"
module single_vector_interrupt_control
  import svic_pkg::*;
(
  input  wire logic        clk_sys,             // System clock, 40 MHz.
  input  wire logic        rst_n,               // Asynchronous reset, active low.
  input  wire logic        psel,                // APB select.
  input  wire logic        penable,             // APB enable.
  input  wire logic        pwrite,              // APB write.
  input  wire logic [11:0] paddr,               // APB byte address.
  input  wire logic [31:0] pwdata,              // APB write data.
  output logic      [31:0] prdata,              // APB read data.
  output logic             pready,              // APB ready.
  output logic             pslverr,             // APB error on unmapped address.
  input  wire logic [7:0]  periph_evt,          // Timer, serial and watch events.
  input  wire logic [6:0]  port1_pin,           // Port 1 external pins.
  input  wire logic [5:0]  port3_pin,           // Port 3 external pins.
  input  wire logic        port4_pin,           // Port 4 external pin.
  input  wire logic        port5_pin,           // Port 5 external pin.
  input  wire logic        instr_done,          // Core finishes an instruction.
  input  wire logic        global_irq_on_op,    // Core executes enable-interrupt.
  input  wire logic        global_irq_off_op,   // Core executes disable-interrupt.
  input  wire logic        return_from_service, // Core executes interrupt return.
  input  wire logic [15:0] pc_now,              // Program counter to save.
  input  wire logic [7:0]  flags_now,           // Flags to save.
  input  wire logic        stack_push_ready,    // Core accepted the pushed byte.
  input  wire logic [7:0]  vec_rd_data,         // Program memory byte.
  input  wire logic        vec_rd_valid,        // Program memory byte valid.
  output logic             irq_ack,             // Interrupt acknowledge pulse.
  output logic             svc_busy,            // Machine cycle in progress.
  output logic             stack_push_valid,    // Byte to push is valid.
  output logic      [7:0]  stack_push_data,     // Byte to push.
  output logic             vec_rd_req,          // Program memory read request.
  output logic      [15:0] vec_rd_addr,         // Program memory read address.
  output logic             branch_valid,        // Branch to service routine.
  output logic      [15:0] branch_addr,         // Service routine address.
  output logic      [2:0]  page_sel,            // Page selection field.
  output logic             irq_out              // Level interrupt to the system.
);

  svc_state_e        state_r;
  svc_state_e        state_nxt;
  logic [7:0]        sysmode_r;
  logic [7:0]        en_ts_r;
  logic [6:0]        en_p1_r;
  logic [7:0]        en_px_r;
  logic [`N_EVT-1:0] evt_stat_r;
  logic [`N_EVT-1:0] evt_mask_r;
  logic [15:0]       pc_hold_r;
  logic [7:0]        flags_hold_r;
  logic [7:0]        vec_hi_r;
  logic [7:0]        vec_lo_r;
  logic [7:0]        push_data_r;
  logic [15:0]       rd_addr_r;
  logic [15:0]       br_addr_r;
  logic [31:0]       prdata_r;
  logic              pslverr_r;
  logic [7:0]        pend_ts;
  logic [6:0]        pend_p1;
  logic [7:0]        pend_px;
  logic [9:0]        reg_idx;
  logic              wr_acc;
  logic              setup_ph;
  logic              gie;
  logic              svc_req;
  logic [`N_EVT-1:0] evt_set;

  assign reg_idx  = paddr[11:2];
  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite;
  assign gie      = sysmode_r[`GIE_BIT];

  // Sources set flags in any state; no hardware priority between them.
  pending_flag_bank #(.W(8), .SYNC_IN(1'b0)) u_pend_ts
  (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .src_in     (periph_evt),
    .wr_stb     (wr_acc && reg_idx == `IDX_PEND_TS),
    .wr_data    (pwdata[7:0]),
    .pend_flags (pend_ts)
  );

  pending_flag_bank #(.W(7), .SYNC_IN(1'b1)) u_pend_p1
  (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .src_in     (port1_pin),
    .wr_stb     (wr_acc && reg_idx == `IDX_PEND_P1),
    .wr_data    (pwdata[6:0]),
    .pend_flags (pend_p1)
  );

  pending_flag_bank #(.W(8), .SYNC_IN(1'b1)) u_pend_px
  (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .src_in     ({port5_pin, port4_pin, port3_pin}),
    .wr_stb     (wr_acc && reg_idx == `IDX_PEND_PX),
    .wr_data    (pwdata[7:0]),
    .pend_flags (pend_px)
  );

  assign svc_req = gie & (|(pend_ts & en_ts_r) | |(pend_p1 & en_p1_r) | |(pend_px & en_px_r));

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:   if (svc_req && instr_done) state_nxt = ST_ACK;
      ST_ACK:    state_nxt = ST_PCL;
      ST_PCL:    if (stack_push_ready) state_nxt = ST_PCH;
      ST_PCH:    if (stack_push_ready) state_nxt = ST_FLG;
      ST_FLG:    if (stack_push_ready) state_nxt = ST_VHI;
      ST_VHI:    if (vec_rd_valid) state_nxt = ST_VLO;
      ST_VLO:    if (vec_rd_valid) state_nxt = ST_BRANCH;
      ST_BRANCH: state_nxt = ST_IDLE;
      default:   state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // Context is frozen at acknowledge so the pushes see one consistent PC.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc_hold_r    <= 16'h0000;
      flags_hold_r <= 8'h00;
    end
    else if (state_nxt == ST_ACK)
    begin
      pc_hold_r    <= pc_now;
      flags_hold_r <= flags_now;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      push_data_r <= 8'h00;
      rd_addr_r   <= `VEC_HI_ADDR;
    end
    else
    begin
      case (state_nxt)
        ST_PCL:  push_data_r <= pc_hold_r[7:0];
        ST_PCH:  push_data_r <= pc_hold_r[15:8];
        ST_FLG:  push_data_r <= flags_hold_r;
        default: push_data_r <= push_data_r;
      endcase
      if (state_nxt == ST_VLO)
        rd_addr_r <= `VEC_LO_ADDR;
      else if (state_nxt == ST_VHI)
        rd_addr_r <= `VEC_HI_ADDR;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vec_hi_r  <= 8'h00;
      vec_lo_r  <= 8'h00;
      br_addr_r <= 16'h0000;
    end
    else
    begin
      if (state_r == ST_VHI && vec_rd_valid)
        vec_hi_r <= vec_rd_data;
      if (state_r == ST_VLO && vec_rd_valid)
      begin
        vec_lo_r  <= vec_rd_data;
        br_addr_r <= {vec_hi_r, vec_rd_data};
      end
    end
  end

  assign irq_ack          = (state_r == ST_ACK);
  assign svc_busy         = (state_r != ST_IDLE);
  assign stack_push_valid = (state_r == ST_PCL) | (state_r == ST_PCH) | (state_r == ST_FLG);
  assign stack_push_data  = push_data_r;
  assign vec_rd_req       = (state_r == ST_VHI) | (state_r == ST_VLO);
  assign vec_rd_addr      = rd_addr_r;
  assign branch_valid     = (state_r == ST_BRANCH);
  assign branch_addr      = br_addr_r;
  assign page_sel         = sysmode_r[`PAGE_MSB:0];

  // The acknowledge clear outranks every other change of the global enable.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      sysmode_r <= `SYSMODE_RST;
    else if (state_r == ST_ACK)
      sysmode_r[`GIE_BIT] <= 1'b0;
    else if (global_irq_on_op || return_from_service)
      sysmode_r[`GIE_BIT] <= 1'b1;
    else if (global_irq_off_op)
      sysmode_r[`GIE_BIT] <= 1'b0;
    else if (wr_acc && reg_idx == `IDX_SYSMODE)
      sysmode_r <= {4'h0, pwdata[3:0]};
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_ts_r    <= `EN_RST;
      en_p1_r    <= 7'h00;
      en_px_r    <= `EN_RST;
      evt_mask_r <= '0;
    end
    else if (wr_acc)
    begin
      if (reg_idx == `IDX_EN_TS)
        en_ts_r <= pwdata[7:0];
      else if (reg_idx == `IDX_EN_P1)
        en_p1_r <= pwdata[6:0];
      else if (reg_idx == `IDX_EN_PX)
        en_px_r <= pwdata[7:0];
      else if (reg_idx == `IDX_EVT_MASK)
        evt_mask_r <= pwdata[`N_EVT-1:0];
    end
  end

  assign evt_set[`EVT_ACK]    = (state_r == ST_ACK);
  assign evt_set[`EVT_RET]    = return_from_service;
  assign evt_set[`EVT_BRANCH] = (state_r == ST_BRANCH);

  // Write one to clear; an event in the same cycle keeps its bit set.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      evt_stat_r <= '0;
    else if (wr_acc && reg_idx == `IDX_EVT_STAT)
      evt_stat_r <= evt_set | (evt_stat_r & ~pwdata[`N_EVT-1:0]);
    else
      evt_stat_r <= evt_set | evt_stat_r;
  end

  assign irq_out = |(evt_stat_r & evt_mask_r);

  // Read data and error are latched in the setup cycle; zero wait states.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else if (setup_ph)
    begin
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      if (reg_idx == `IDX_SYSMODE)
        prdata_r[7:0] <= sysmode_r;
      else if (reg_idx == `IDX_PEND_TS)
        prdata_r[7:0] <= pend_ts;
      else if (reg_idx == `IDX_PEND_P1)
        prdata_r[6:0] <= pend_p1;
      else if (reg_idx == `IDX_PEND_PX)
        prdata_r[7:0] <= pend_px;
      else if (reg_idx == `IDX_EN_TS)
        prdata_r[7:0] <= en_ts_r;
      else if (reg_idx == `IDX_EN_P1)
        prdata_r[6:0] <= en_p1_r;
      else if (reg_idx == `IDX_EN_PX)
        prdata_r[7:0] <= en_px_r;
      else if (reg_idx == `IDX_EVT_STAT)
        prdata_r[`N_EVT-1:0] <= evt_stat_r;
      else if (reg_idx == `IDX_EVT_MASK)
        prdata_r[`N_EVT-1:0] <= evt_mask_r;
      else
        pslverr_r <= 1'b1;
    end
  end

  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;
  assign pready  = 1'b1;

  a_ack_needs_enable: assert property (@(posedge clk_sys) disable iff (!rst_n)
    irq_ack |-> $past(svc_req) && $past(instr_done))
    else $error("acknowledge without enabled request at instruction end");

  a_ack_clears_gie: assert property (@(posedge clk_sys) disable iff (!rst_n)
    irq_ack |=> !gie)
    else $error("global enable not cleared by acknowledge");

  a_ack_single_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    irq_ack |=> !irq_ack ##0 stack_push_valid)
    else $error("acknowledge not followed by push phase");

  a_push_pc_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_PCL) |-> stack_push_data == pc_hold_r[7:0])
    else $error("first push is not the PC low byte");

  a_push_order: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_PCH && stack_push_ready) |=> (state_r == ST_FLG) && stack_push_data == flags_hold_r)
    else $error("flags do not follow PC high byte");

  a_vec_hi_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_VHI) |-> vec_rd_addr == `VEC_HI_ADDR)
    else $error("high vector byte read from wrong address");

  a_branch_target: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_VLO && vec_rd_valid) |=> branch_valid && branch_addr == {vec_hi_r, $past(vec_rd_data)})
    else $error("branch address not built from vector bytes");

  a_ret_sets_gie: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (return_from_service && state_r != ST_ACK) |=> gie)
    else $error("return did not set global enable");

  a_pend_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(wr_acc && reg_idx == `IDX_PEND_TS) |=> (pend_ts & $past(pend_ts)) == $past(pend_ts))
    else $error("pending flag lost without a clearing write");

endmodule

//--- test/core_side_model.sv
`timescale 1ns/10ps
module core_side_model
#(
  parameter logic [7:0] VEC_HI = 8'h3c, // Byte stored at 0000.
  parameter logic [7:0] VEC_LO = 8'ha5  // Byte stored at 0001.
)
(
  input  wire logic        clk_sys,          // System clock.
  input  wire logic        rst_n,            // Reset, active low.
  input  wire logic        slow,             // Stall every other cycle.
  input  wire logic        stack_push_valid, // Byte offered for the stack.
  output logic             stack_push_ready, // Byte taken.
  input  wire logic        vec_rd_req,       // Program memory read.
  input  wire logic [15:0] vec_rd_addr,      // Read address.
  output logic             vec_rd_valid,     // Read answered.
  output logic      [7:0]  vec_rd_data       // Read byte.
);
  logic       go_r;
  logic [7:0] last_r;
  logic [7:0] mem_byte;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      go_r <= 1'b1;
    else
      go_r <= slow ? ~go_r : 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      last_r <= 8'h00;
    else if (vec_rd_valid)
      last_r <= mem_byte;
  end

  assign mem_byte = (vec_rd_addr == 16'h0000) ? VEC_HI : ((vec_rd_addr == 16'h0001) ? VEC_LO : 8'h5a);
  assign stack_push_ready = stack_push_valid & go_r;
  assign vec_rd_valid = vec_rd_req & go_r;
  // Idle data lines show the inverse of the last byte, so a read taken too early cannot match.
  assign vec_rd_data = vec_rd_valid ? mem_byte : ~last_r;
endmodule

//--- test/single_vector_interrupt_control_test.sv
`timescale 1ns/10ps
`include "svic_params.svh"
module single_vector_interrupt_control_test;
  localparam logic [7:0] VHI = 8'h3c;
  localparam logic [7:0] VLO = 8'ha5;
  logic        clk_sys = 1'b0;
  logic        rst_n, psel, penable, pwrite, pready, pslverr, instr_done, global_irq_on_op;
  logic        global_irq_off_op, return_from_service, stack_push_ready, stack_push_valid, vec_rd_valid;
  logic        vec_rd_req, irq_ack, svc_busy, branch_valid, irq_out, port4_pin, port5_pin, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rng;
  logic [15:0] pc_now, vec_rd_addr, branch_addr;
  logic [7:0]  flags_now, periph_evt, stack_push_data, vec_rd_data;
  logic [6:0]  port1_pin;
  logic [5:0]  port3_pin;
  logic [2:0]  page_sel;
  int          n_errors, check_count, n_ack;
  logic [7:0]  push_q[$];
  logic [15:0] br_q[$];
  logic [32:0] rd_q[$];

  single_vector_interrupt_control i_dut (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .periph_evt, .port1_pin, .port3_pin, .port4_pin, .port5_pin, .instr_done,
    .global_irq_on_op, .global_irq_off_op, .return_from_service, .pc_now, .flags_now, .stack_push_ready,
    .vec_rd_data, .vec_rd_valid, .irq_ack, .svc_busy, .stack_push_valid, .stack_push_data, .vec_rd_req,
    .vec_rd_addr, .branch_valid, .branch_addr, .page_sel, .irq_out);
  core_side_model #(.VEC_HI(VHI), .VEC_LO(VLO)) i_core (.clk_sys, .rst_n, .slow, .stack_push_valid,
    .stack_push_ready, .vec_rd_req, .vec_rd_addr, .vec_rd_valid, .vec_rd_data);

  always #12.5 clk_sys = ~clk_sys;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [11:0] ad(input logic [9:0] i);
    return {i, 2'b00};
  endfunction

  task automatic cmp_val(input logic [32:0] got, input logic [32:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    cmp_val({32'h0, got}, {32'h0, exp}, what);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic timed_out(input string what);
    n_errors++;
    $display("[FAIL] %0t wait for %s ran out", $time, what);
    test_done;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
      if (n > 20)
        timed_out("pready");
    end
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic er);
    rd_q.push_back({er, e});
    apb(1'b0, a, 32'h0);
  endtask

  // Pulses one core strobe for a single cycle: 0 enable, 1 disable, 2 return, 3 instruction done.
  task automatic op(input int k);
    @(posedge clk_sys);
    global_irq_on_op <= (k == 0);
    global_irq_off_op <= (k == 1);
    return_from_service <= (k == 2);
    instr_done <= (k == 3);
    @(posedge clk_sys);
    {global_irq_on_op, global_irq_off_op, return_from_service, instr_done} <= 4'h0;
  endtask

  task automatic pulse_evt(input logic [7:0] v);
    @(posedge clk_sys);
    periph_evt <= v;
    @(posedge clk_sys);
    periph_evt <= 8'h00;
    tick(2);
  endtask

  task automatic service(input logic s, input string name);
    int a0;
    int n;
    rng = xs(rng);
    a0 = n_ack;
    n = 0;
    @(posedge clk_sys);
    slow <= s;
    pc_now <= rng[15:0];
    flags_now <= rng[23:16];
    push_q.push_back(rng[7:0]);
    push_q.push_back(rng[15:8]);
    push_q.push_back(rng[23:16]);
    br_q.push_back({VHI, VLO});
    op(3);
    // The core moves on after the acknowledge edge; the pushed bytes must still be the frozen context.
    pc_now <= ~rng[15:0];
    flags_now <= ~rng[23:16];
    while (svc_busy !== 1'b0 || n < 2)
    begin
      @(posedge clk_sys);
      n++;
      if (n > 200)
        timed_out("machine cycle");
    end
    cmp_val(33'(n_ack - a0), 33'h1, "acknowledge count");
    cmp_val(33'(push_q.size() + br_q.size()), 33'h0, "transfers left");
    $display("test service %s done", name);
  endtask

  always @(posedge clk_sys)
  begin
    if (irq_ack === 1'b1)
      n_ack++;
    if (stack_push_valid === 1'b1 && stack_push_ready === 1'b1)
    begin
      if (push_q.size() == 0)
        push_q.push_back(~stack_push_data);
      cmp_val(33'(stack_push_data), 33'(push_q.pop_front()), "stack byte");
    end
    if (branch_valid === 1'b1)
    begin
      if (br_q.size() == 0)
        br_q.push_back(~branch_addr);
      cmp_val(33'(branch_addr), 33'(br_q.pop_front()), "branch address");
    end
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
    begin
      if (rd_q.size() == 0)
        rd_q.push_back(~{pslverr, prdata});
      cmp_val({pslverr, prdata}, rd_q.pop_front(), "register read");
    end
  end

  initial
  begin
    {rst_n, psel, penable, pwrite, instr_done, global_irq_on_op, slow} = 7'h00;
    {global_irq_off_op, return_from_service, port4_pin, port5_pin} = 4'h0;
    {paddr, pwdata, pc_now, flags_now, periph_evt, port1_pin, port3_pin} = 89'h0;
    {n_errors, check_count, n_ack} = 96'h0;
    rng = 32'hb2ee;
    tick(16);
    rst_n <= 1'b1;
    rd(ad(`IDX_SYSMODE), 32'h00, 1'b0);
    rd(ad(`IDX_PEND_TS), 32'h00, 1'b0);
    rd(ad(`IDX_EN_TS), 32'h00, 1'b0);
    rd(12'hffc, 32'h00, 1'b1);
    cmp_bit(irq_out, 1'b0, "irq after reset");
    $display("test reset done");
    pulse_evt(8'h80);
    rd(ad(`IDX_PEND_TS), 32'h80, 1'b0);
    wr(ad(`IDX_PEND_TS), 32'hff);
    rd(ad(`IDX_PEND_TS), 32'h80, 1'b0);
    op(0);
    rd(ad(`IDX_SYSMODE), 32'h08, 1'b0);
    op(3);
    tick(4);
    cmp_val(33'(n_ack), 33'h0, "ack with source off");
    op(1);
    rd(ad(`IDX_SYSMODE), 32'h00, 1'b0);
    wr(ad(`IDX_EN_TS), 32'h80);
    op(3);
    tick(4);
    cmp_val(33'(n_ack), 33'h0, "ack with global off");
    wr(ad(`IDX_SYSMODE), 32'hfd);
    rd(ad(`IDX_SYSMODE), 32'h0d, 1'b0);
    cmp_val(33'(page_sel), 33'h5, "page field");
    tick(10);
    cmp_val(33'(n_ack), 33'h0, "ack inside instruction");
    $display("test enables done");
    service(1'b0, "watch timer");
    rd(ad(`IDX_SYSMODE), 32'h05, 1'b0);
    rd(ad(`IDX_PEND_TS), 32'h80, 1'b0);
    wr(ad(`IDX_PEND_TS), 32'h7f);
    rd(ad(`IDX_PEND_TS), 32'h00, 1'b0);
    op(2);
    rd(ad(`IDX_SYSMODE), 32'h0d, 1'b0);
    rd(ad(`IDX_EVT_STAT), 32'h07, 1'b0);
    cmp_bit(irq_out, 1'b0, "irq masked");
    wr(ad(`IDX_EVT_MASK), 32'h02);
    tick(2);
    cmp_bit(irq_out, 1'b1, "irq raised");
    wr(ad(`IDX_EVT_STAT), 32'h02);
    tick(2);
    cmp_bit(irq_out, 1'b0, "irq cleared");
    rd(ad(`IDX_EVT_STAT), 32'h05, 1'b0);
    wr(ad(`IDX_EVT_MASK), 32'h00);
    wr(ad(`IDX_EVT_STAT), 32'h05);
    $display("test event status done");
    wr(ad(`IDX_EN_P1), 32'h04);
    @(posedge clk_sys);
    port1_pin <= 7'h04;
    tick(6);
    rd(ad(`IDX_PEND_P1), 32'h04, 1'b0);
    service(1'b1, "port pin");
    wr(ad(`IDX_PEND_P1), 32'hfb);
    rd(ad(`IDX_PEND_P1), 32'h00, 1'b0);
    op(2);
    rd(ad(`IDX_SYSMODE), 32'h0d, 1'b0);
    for (int i = 0; i < 7; i++)
    begin
      pulse_evt(8'h01 << i);
      rd(ad(`IDX_PEND_TS), 32'h01 << i, 1'b0);
      wr(ad(`IDX_PEND_TS), ~(32'h01 << i));
    end
    @(posedge clk_sys);
    {port1_pin, port3_pin, port4_pin, port5_pin} <= 15'h7fff;
    tick(6);
    rd(ad(`IDX_PEND_P1), 32'h7b, 1'b0);
    rd(ad(`IDX_PEND_PX), 32'hff, 1'b0);
    tick(2);
    cmp_val(33'(rd_q.size()), 33'h0, "reads left");
    $display("test sources done");
    test_done;
  end
endmodule
